// ==== verilog/iam_pkg.sv ====
// constants and carriers for the indirect address mapper
package iam_pkg;
  localparam logic [15:0] LIN_BASE = 16'h2000;
  localparam logic [15:0] LIN_LAST = 16'h29AF;
  localparam logic [7:0] GPR_BLOCK_BYTES = 8'h50;
  localparam logic [6:0] GPR_FIRST_OFS = 7'h20;
  localparam logic [6:0] COMMON_FIRST_OFS = 7'h70;
  localparam logic [7:0] EE_WINDOW_HI = 8'h70;
  localparam int FLASH_BIT_POS = 15;
  localparam logic [7:0] EMPTY_READ = 8'h00;
  localparam logic [1:0] EXTRA_WAIT_CYCLES = 2'h1;
  localparam logic [6:0] BANK_COUNT = 7'h20;

  typedef enum logic [1:0] {
    IAM_T_RAM,
    IAM_T_EE,
    IAM_T_FLASH,
    IAM_T_NONE
  } iam_target_e;

  // one pointer access from the core
  typedef struct packed {
    logic [15:0] pointer;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } iam_req_s;

  // one resolved memory access
  typedef struct packed {
    iam_target_e target;
    logic [12:0] ram_addr;
    logic [7:0] ee_addr;
    logic [14:0] flash_addr;
  } iam_map_s;
endpackage

// ==== verilog/iam_mapper.sv ====
// indirect pointer decoder onto banked ram, data eeprom and program flash
// Functional notes
// R01: 0x2000..0x29AF is linear ram window
// R02: 80-byte bank blocks chained without gaps
// R03: unimplemented locations read as 0x00
// R04: common memory never reached linearly
// R05: high byte 0x70 reads eeprom by low byte
// R06: eeprom window ignores writes
// R07: eeprom read takes one extra cycle
// R08: pointer msb set selects flash word address
// R09: flash read returns low eight bits only
// R10: flash window ignores writes
// R11: flash access takes one extra cycle
// R12: low pointers use bank and 7-bit offset
`timescale 1ns/100ps
module iam_mapper #(
  parameter int RAM_AW = 13,
  parameter int FLASH_AW = 15
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire iam_pkg::iam_req_s req,
  output logic req_ready,
  output logic rdata_valid,
  output logic [7:0] rdata,
  output logic [RAM_AW-1:0] ram_addr,
  output logic ram_rd,
  output logic ram_wr,
  output logic [7:0] ram_wdata,
  input wire logic [7:0] ram_rdata,
  output logic [7:0] ee_addr,
  output logic ee_rd,
  input wire logic [7:0] ee_rdata,
  output logic [FLASH_AW-1:0] flash_addr,
  output logic flash_rd,
  input wire logic [13:0] flash_rdata
);

  // resolve a pointer into a target and array address
  function automatic iam_pkg::iam_map_s map_pointer(input logic [15:0] p);
    iam_pkg::iam_map_s m;
    logic [15:0] lin;
    logic [6:0] bank;
    logic [6:0] ofs;
    m = '0;
    lin = p - iam_pkg::LIN_BASE;
    bank = 7'(lin / 16'(iam_pkg::GPR_BLOCK_BYTES));
    ofs = 7'(lin % 16'(iam_pkg::GPR_BLOCK_BYTES));
    if (p[iam_pkg::FLASH_BIT_POS]) begin
      m.target = iam_pkg::IAM_T_FLASH; // see R08
      m.flash_addr = p[14:0];
    end else if (p[15:8] == iam_pkg::EE_WINDOW_HI) begin
      m.target = iam_pkg::IAM_T_EE; // see R05
      m.ee_addr = p[7:0];
    end else if (p >= iam_pkg::LIN_BASE && p <= iam_pkg::LIN_LAST) begin
      // offset 0x20 onward of each bank, never into the common bytes at 0x70
      m.target = iam_pkg::IAM_T_RAM; // see R01 see R02 see R04
      m.ram_addr = {bank[5:0], ofs + iam_pkg::GPR_FIRST_OFS};
    end else if (p < iam_pkg::LIN_BASE && {1'b0, p[12:7]} < iam_pkg::BANK_COUNT) begin
      // bank field compared at 7 bits so the full bank count stays representable
      m.target = iam_pkg::IAM_T_RAM; // see R12
      m.ram_addr = p[12:0];
    end else begin
      m.target = iam_pkg::IAM_T_NONE; // see R03
    end
    return m;
  endfunction

  typedef enum logic [1:0] {
    IAM_S_IDLE,
    IAM_S_WAIT
  } iam_state_e;

  iam_state_e state_reg, state_next;
  iam_pkg::iam_target_e tgt_reg, tgt_next;
  logic [1:0] wait_reg, wait_next;
  logic [7:0] rdata_reg, rdata_next;
  logic valid_reg, valid_next;
  iam_pkg::iam_map_s map_now;
  logic rd_reg, rd_next;
  logic take_ok;

  assign map_now = map_pointer(req.pointer);
  // ram path reaches the array the same cycle; slow windows hold ready low
  assign req_ready = (state_reg == IAM_S_IDLE);
  // strobes only on an edge that really takes the request; a frozen core must not write
  assign take_ok = req_ready && clk_en;
  assign ram_addr = RAM_AW'(map_now.ram_addr);
  assign ram_wdata = req.wdata;
  assign ram_rd = take_ok && req.rd && map_now.target == iam_pkg::IAM_T_RAM;
  assign ram_wr = take_ok && req.wr && map_now.target == iam_pkg::IAM_T_RAM;
  assign ee_addr = map_now.ee_addr;
  assign ee_rd = take_ok && req.rd && map_now.target == iam_pkg::IAM_T_EE; // see R06
  assign flash_addr = FLASH_AW'(map_now.flash_addr);
  // a write into the flash window still pulses flash_rd; no write strobe leaves the decoder
  assign flash_rd = take_ok && (req.rd || req.wr) && map_now.target == iam_pkg::IAM_T_FLASH; // see R10
  assign rdata = rdata_reg;
  assign rdata_valid = valid_reg;

  // access sequencer
  always_comb begin
    state_next = state_reg;
    tgt_next = tgt_reg;
    wait_next = wait_reg;
    rdata_next = rdata_reg;
    valid_next = 1'b0;
    rd_next = rd_reg;
    unique case (state_reg)
      IAM_S_IDLE: begin
        if (req.rd || req.wr) begin
          tgt_next = map_now.target;
          rd_next = req.rd;
          unique case (map_now.target)
            iam_pkg::IAM_T_RAM: begin
              if (req.rd) begin
                rdata_next = ram_rdata;
              end
              valid_next = req.rd;
            end
            iam_pkg::IAM_T_NONE: begin
              if (req.rd) begin
                rdata_next = iam_pkg::EMPTY_READ; // see R03
              end
              valid_next = req.rd;
            end
            default: begin
              // eeprom or flash: one more instruction cycle
              wait_next = iam_pkg::EXTRA_WAIT_CYCLES; // see R07 see R11
              state_next = IAM_S_WAIT;
            end
          endcase
        end
      end
      IAM_S_WAIT: begin
        wait_next = wait_reg - 2'h1;
        // last wait cycle: slow array data has settled on the held pointer
        if (wait_reg == 2'h1) begin
          state_next = IAM_S_IDLE;
          // writes into the rom windows get no answer and leave rdata alone
          valid_next = rd_reg;
          if (rd_reg && tgt_reg == iam_pkg::IAM_T_EE) begin
            rdata_next = ee_rdata;
          end else if (rd_reg) begin
            rdata_next = flash_rdata[7:0]; // see R09
          end
        end
      end
    endcase
  end

  // registers frozen while clk_en is low
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg <= IAM_S_IDLE;
      tgt_reg <= iam_pkg::IAM_T_NONE;
      wait_reg <= 2'h0;
      rdata_reg <= 8'h00;
      valid_reg <= 1'b0;
      rd_reg <= 1'b0;
    end else if (clk_en) begin
      state_reg <= state_next;
      tgt_reg <= tgt_next;
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
      valid_reg <= valid_next;
      rd_reg <= rd_next;
    end
  end

  // ram read answers one edge after the request
  sequence s_ram_rd;
    req_ready && req.rd && !req.pointer[15] && req.pointer[15:8] != 8'h70 && clk_en;
  endsequence

  chk_linear_first: assert property (@(posedge ref_clk) disable iff (!rst_n) // see R01
    (req.pointer == 16'h2000) |-> (ram_addr[6:0] == 7'h20 && ram_addr[12:7] == 6'h00))
    else $error("linear base mapped wrong");
  chk_linear_chain: assert property (@(posedge ref_clk) disable iff (!rst_n) // see R02
    (req.pointer == 16'h2050) |-> (ram_addr == 13'h00A0))
    else $error("linear block chaining broken");
  chk_common_skip: assert property (@(posedge ref_clk) disable iff (!rst_n) // see R04
    (req.pointer >= 16'h2000 && req.pointer <= 16'h29AF) |-> (ram_addr[6:0] < 7'h70 && ram_addr[6:0] >= 7'h20))
    else $error("linear hit common memory");
  chk_empty_zero: assert property (@(posedge ref_clk) disable iff (!rst_n) // see R03
    (req_ready && clk_en && req.rd && map_now.target == iam_pkg::IAM_T_NONE) |=> (rdata_valid && rdata == 8'h00))
    else $error("unimplemented read not zero");
  chk_ee_addr: assert property (@(posedge ref_clk) disable iff (!rst_n) // see R05
    (req.pointer[15:8] == 8'h70) |-> (ee_addr == req.pointer[7:0] && !ram_rd && !flash_rd))
    else $error("eeprom window misdecoded");
  chk_ee_nowrite: assert property (@(posedge ref_clk) disable iff (!rst_n) // see R06
    (req.wr && req.pointer[15:8] == 8'h70) |-> (!ram_wr && !ee_rd))
    else $error("eeprom window written");
  // slow window accesses: taken, then one enabled wait edge before the answer
  sequence s_slow_rd;
    req_ready && req.rd && (req.pointer[15] || req.pointer[15:8] == 8'h70) && clk_en;
  endsequence
  sequence s_slow_wr;
    req_ready && req.wr && !req.rd && (req.pointer[15] || req.pointer[15:8] == 8'h70) && clk_en;
  endsequence

  chk_slow_delay: assert property (@(posedge ref_clk) disable iff (!rst_n) // see R07 see R11
    s_slow_rd ##1 clk_en |=> (rdata_valid && !$past(rdata_valid)))
    else $error("slow window timing wrong");
  // a write into a rom window is swallowed without an answer pulse
  chk_slow_nowrite: assert property (@(posedge ref_clk) disable iff (!rst_n) // see R06 see R10
    s_slow_wr ##1 clk_en |=> !rdata_valid)
    else $error("rom window write answered");
  chk_ram_fast: assert property (@(posedge ref_clk) disable iff (!rst_n) // see R07
    s_ram_rd |=> rdata_valid)
    else $error("ram read not single cycle");
  chk_flash_addr: assert property (@(posedge ref_clk) disable iff (!rst_n) // see R08
    req.pointer[15] |-> (flash_addr == req.pointer[14:0] && !ram_wr))
    else $error("flash window misdecoded");
  chk_flash_low: assert property (@(posedge ref_clk) disable iff (!rst_n) // see R09
    (clk_en && state_reg == IAM_S_WAIT && wait_reg == 2'h1 && rd_reg && tgt_reg == iam_pkg::IAM_T_FLASH)
    |=> (rdata == $past(flash_rdata[7:0])))
    else $error("flash byte wrong");
  chk_flash_nowrite: assert property (@(posedge ref_clk) disable iff (!rst_n) // see R10
    (req.wr && req.pointer[15]) |-> !ram_wr)
    else $error("flash window written");
  chk_banked_map: assert property (@(posedge ref_clk) disable iff (!rst_n) // see R12
    (req.pointer < 16'h1000) |-> (ram_addr == req.pointer[12:0]))
    else $error("banked map wrong");

endmodule // iam_mapper

// ==== tb/iam_mem_model.sv ====
// memory arrays behind the mapper: ram, data eeprom and flash rom
`timescale 1ns/100ps
module iam_mem_model (
  input wire logic ref_clk,
  input wire logic [12:0] ram_addr,
  input wire logic ram_rd,
  input wire logic ram_wr,
  input wire logic [7:0] ram_wdata,
  output logic [7:0] ram_rdata,
  input wire logic [7:0] ee_addr,
  output logic [7:0] ee_rdata,
  input wire logic [14:0] flash_addr,
  output logic [13:0] flash_rdata
);
  logic [7:0] mem [0:8191];
  // ram write lands on the edge that takes it
  always_ff @(posedge ref_clk) begin
    if (ram_wr) mem[ram_addr] <= ram_wdata;
  end
  // idle read bus shows a scrambled byte, never the last one
  assign ram_rdata = ram_rd ? mem[ram_addr] : ~ram_addr[7:0];
  // roms answer continuously; neither has any write path
  assign ee_rdata = ee_addr ^ 8'h3C;
  assign flash_rdata = {6'h2A, flash_addr[7:0] ^ flash_addr[14:7]};
endmodule // iam_mem_model

// ==== tb/test_iam_mapper.sv ====
// self-checking bench for the indirect address mapper
`timescale 1ns/100ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_count++; $display("FAIL t=%0t got=%h exp=%h", $time, a, e); end end
module test_iam_mapper;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  iam_pkg::iam_req_s req = '0;
  logic req_ready, rdata_valid, ram_rd, ram_wr;
  logic [7:0] rdata, ram_wdata, ram_rdata, ee_addr, ee_rdata;
  logic [12:0] ram_addr;
  logic [14:0] flash_addr;
  logic [13:0] flash_rdata;
  logic [15:0] seed = 16'h002F;
  logic [15:0] corner [4] = '{16'h2000, 16'h204F, 16'h2050, 16'h29AF};
  logic [15:0] holes [5] = '{16'h1000, 16'h1FFF, 16'h29B0, 16'h6FFF, 16'h7100};
  int err_count = 0;
  int n_checks = 0;

  // 125 MHz core clock
  initial forever #4 ref_clk = ~ref_clk;

  iam_mapper iam_mapper_i (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .req(req),
    .req_ready(req_ready), .rdata_valid(rdata_valid), .rdata(rdata), .ram_addr(ram_addr),
    .ram_rd(ram_rd), .ram_wr(ram_wr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata),
    .ee_addr(ee_addr), .ee_rd(), .ee_rdata(ee_rdata), .flash_addr(flash_addr), .flash_rd(),
    .flash_rdata(flash_rdata));
  iam_mem_model iam_mem_model_i (.ref_clk(ref_clk), .ram_addr(ram_addr), .ram_rd(ram_rd),
    .ram_wr(ram_wr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .ee_addr(ee_addr),
    .ee_rdata(ee_rdata), .flash_addr(flash_addr), .flash_rdata(flash_rdata));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // banked pointer a linear pointer must alias; offset never reaches common bytes
  function automatic logic [15:0] bank_ptr(input logic [15:0] p);
    logic [15:0] l;
    l = p - 16'h2000;
    return ((l / 16'h0050) << 7) + 16'h0020 + (l % 16'h0050);
  endfunction

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // one access: hold until taken, then time the answer in cycles
  task automatic acc(input logic [15:0] p, input logic w, input logic [7:0] d, input logic [7:0] exp,
    input int lat);
    int n;
    n = 0;
    @(posedge ref_clk);
    req <= '{pointer: p, rd: !w, wr: w, wdata: d};
    @(negedge ref_clk);
    while (req_ready !== 1'b1) begin
      n++;
      if (n > 20) begin err_count++; wrap_up(); end
      @(negedge ref_clk);
    end
    @(posedge ref_clk);
    // pointer stays put so slow roms keep the right address
    req <= '{pointer: p, rd: 1'b0, wr: 1'b0, wdata: d};
    if (!w) begin
      n = 0;
      do begin @(negedge ref_clk); n++; end while (rdata_valid !== 1'b1 && n < 20);
      if (rdata_valid !== 1'b1) begin
        err_count++;
        wrap_up();
      end
      `CHK(n, lat)
      `CHK(rdata, exp)
    end
  endtask

  initial begin
    logic [15:0] p;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    `CHK(rdata, 8'h00)
    `CHK(req_ready, 1'b1)
    // corners first, then random spans, each window written then read
    for (int i = 0; i < 44; i++) begin
      seed = lfsr(seed);
      p = (i < 4) ? corner[i] : 16'h2000 + seed % 16'h09B0;
      acc(p, 1'b1, seed[15:8], 8'h00, 0);
      acc(bank_ptr(p), 1'b0, 8'h00, seed[15:8], 1);
      acc(p, 1'b0, 8'h00, seed[15:8], 1);
      acc({8'h70, seed[7:0]}, 1'b1, ~seed[7:0], 8'h00, 0);
      acc({8'h70, seed[7:0]}, 1'b0, 8'h00, seed[7:0] ^ 8'h3C, 2);
      acc({1'b1, seed[14:0]}, 1'b1, 8'hFF, 8'h00, 0);
      acc({1'b1, seed[14:0]}, 1'b0, 8'h00, seed[7:0] ^ seed[14:7], 2);
    end
    // unimplemented places answer zero on the fast path
    foreach (holes[i]) acc(holes[i], 1'b0, 8'h00, 8'h00, 1);
    // a frozen enable stretches a slow read by exactly the stalled cycles
    @(posedge ref_clk);
    req <= '{pointer: 16'h7005, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
    @(posedge ref_clk);
    req <= '{pointer: 16'h7005, rd: 1'b0, wr: 1'b0, wdata: 8'h00};
    clk_en <= 1'b0;
    repeat (3) @(posedge ref_clk);
    clk_en <= 1'b1;
    @(negedge ref_clk);
    `CHK({req_ready, rdata_valid}, 2'h0)
    @(negedge ref_clk);
    `CHK({req_ready, rdata_valid, rdata}, {2'h3, 8'h39})
    wrap_up();
  end
endmodule // test_iam_mapper
